// >>> verilog/scad_pkg.sv
// scad_pkg: opcode patterns, clock counts and carrier types of the decoder
package scad_pkg;

  // ----------------------------------------------------------------
  // opcode patterns and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_DW = 8'hFC; // drops direction and width bits
  localparam logic [7:0] MASK_W = 8'hFE; // drops width bit only
  localparam logic [7:0] MASK_REGNUM = 8'hF8; // drops embedded register number
  localparam logic [7:0] OPC_DIFF_RM = 8'h28; // 001010dw
  localparam logic [7:0] OPC_BDIFF_RM = 8'h18; // 000110dw
  localparam logic [7:0] OPC_CMP_RM = 8'h38; // 001110dw
  localparam logic [7:0] OPC_DIFF_ACC = 8'h2C; // 0010110w
  localparam logic [7:0] OPC_BDIFF_ACC = 8'h1C; // 0001110w
  localparam logic [7:0] OPC_CMP_ACC = 8'h3C; // 0011110w
  localparam logic [7:0] OPC_IMM_GRP = 8'h80; // 100000sw
  localparam logic [7:0] OPC_STEP_GRP = 8'hFE; // 1111111w
  localparam logic [7:0] OPC_UNARY_GRP = 8'hF6; // 1111011w
  localparam logic [7:0] OPC_MINUS1_SHORT = 8'h48; // 01001rrr
  localparam logic [7:0] OPC_UBCD_ADD = 8'h37;
  localparam logic [7:0] OPC_UBCD_SUB = 8'h3F;
  localparam logic [7:0] OPC_PBCD_ADD = 8'h27;
  localparam logic [7:0] OPC_PBCD_SUB = 8'h2F;

  // ----------------------------------------------------------------
  // opcode bit positions and modrm fields
  // ----------------------------------------------------------------
  localparam int BIT_W = 0; // width bit
  localparam int BIT_D = 1; // direction bit
  localparam int BIT_S = 1; // sign-extend bit of the immediate group
  localparam logic [1:0] MOD_REG = 2'h3; // addressing form naming a register
  localparam logic [2:0] SEL_DIFF = 3'h5;
  localparam logic [2:0] SEL_BDIFF = 3'h3;
  localparam logic [2:0] SEL_CMP = 3'h7;
  localparam logic [2:0] SEL_MINUS1 = 3'h1;
  localparam logic [2:0] SEL_SIGNFLIP = 3'h3;

  // ----------------------------------------------------------------
  // execution clock counts
  // ----------------------------------------------------------------
  localparam logic [3:0] CLK_NONE = 4'h0;
  localparam logic [3:0] CLK_REG = 4'h2;
  localparam logic [3:0] CLK_MEM_TO_REG = 4'h7;
  localparam logic [3:0] CLK_REG_TO_MEM = 4'h6;
  localparam logic [3:0] CLK_IMM_MEM = 4'h7;
  localparam logic [3:0] CLK_MINUS1_MEM = 4'h6;
  localparam logic [3:0] CLK_CMP_MEM_REG = 4'h5;
  localparam logic [3:0] CLK_CMP_REG_MEM = 4'h6;
  localparam logic [3:0] CLK_CMP_IMM_MEM = 4'h5;
  localparam logic [3:0] CLK_SIGNFLIP_MEM = 4'h6;
  localparam logic [3:0] CLK_ADJUST = 4'h4;

  // ----------------------------------------------------------------
  // immediate byte counts
  // ----------------------------------------------------------------
  localparam logic [2:0] IMM_NONE = 3'h0;
  localparam logic [2:0] IMM_BYTE = 3'h1;
  localparam logic [2:0] IMM_WORD = 3'h2;
  localparam logic [2:0] IMM_DWORD = 3'h4;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // operation recognised
  typedef enum logic [3:0] {
    OP_NONE, OP_DIFF, OP_BDIFF, OP_MINUS1, OP_CMP, OP_SIGNFLIP,
    OP_UBCD_ADD, OP_UBCD_SUB, OP_PBCD_ADD, OP_PBCD_SUB
  } scad_op_t;

  // decoder sequence
  typedef enum logic [1:0] {ST_OPCODE, ST_MODRM, ST_EXEC} scad_fsm_t;

  // one byte from the prefetch queue
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } scad_byte_t;

  // decoded instruction record
  typedef struct packed {
    logic recognised; // opcode belongs to this group
    scad_op_t op; // operation
    logic wide; // word or doubleword operand
    logic dir_to_reg; // register field is the destination
    logic sext; // 8-bit immediate sign-extended
    logic reg_operand; // operand is a register, not memory
    logic writes_result; // false for compare
    logic prot; // protected mode at decode
    logic [2:0] reg_num; // register of the short forms
    logic [2:0] imm_bytes; // immediate bytes that follow
    logic [3:0] clocks; // execution clock count
  } scad_info_t;

  // decoder state
  typedef struct packed {
    scad_fsm_t fsm;
    logic [7:0] opc;
    scad_info_t info;
    logic dec_valid;
    logic illegal;
  } scad_state_t;

  // execution timer state
  typedef struct packed {
    logic [3:0] cnt;
    logic done;
  } scad_tmr_t;

endpackage

// >>> verilog/scad_imm_len.sv
// scad_imm_len: number of immediate bytes that follow an opcode
`timescale 1ns/10ps
module scad_imm_len (
  // opcode and operand size
  input wire logic [7:0] opc,
  input wire logic op32,
  // result
  output logic [2:0] imm_bytes
);

  // ----------------------------------------------------------------
  // immediate length decode
  // ----------------------------------------------------------------
  logic [2:0] full_len; // length of a full-width immediate

  // full immediate follows the operand size attribute
  assign full_len = op32 ? scad_pkg::IMM_DWORD : scad_pkg::IMM_WORD;

  // accumulator short forms and the immediate group carry data
  always_comb begin
    imm_bytes = scad_pkg::IMM_NONE;
    if ((opc & scad_pkg::MASK_W) == scad_pkg::OPC_DIFF_ACC ||
        (opc & scad_pkg::MASK_W) == scad_pkg::OPC_BDIFF_ACC ||
        (opc & scad_pkg::MASK_W) == scad_pkg::OPC_CMP_ACC) begin
      // byte when width bit clear, else full width
      imm_bytes = opc[scad_pkg::BIT_W] ? full_len : scad_pkg::IMM_BYTE;
    end else if ((opc & scad_pkg::MASK_DW) == scad_pkg::OPC_IMM_GRP) begin
      // sign bit or byte width shortens it to one byte
      if (opc[scad_pkg::BIT_S] || !opc[scad_pkg::BIT_W]) begin
        imm_bytes = scad_pkg::IMM_BYTE;
      end else begin
        imm_bytes = full_len;
      end
    end
  end

endmodule

// >>> verilog/scad_timer.sv
// scad_timer: counts down the execution clocks of a decoded instruction
`timescale 1ns/10ps
module scad_timer (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // load
  input wire logic load,
  input wire logic [3:0] load_cnt,
  // status
  output logic busy,
  output logic last,
  output logic done
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  scad_pkg::scad_tmr_t st_reg; // registered state
  scad_pkg::scad_tmr_t st_next; // next state

  // count down to zero, done pulse after the final cycle
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (load) begin
      st_next.cnt = load_cnt;
    end else if (st_reg.cnt != 4'h0) begin
      st_next.cnt = st_reg.cnt - 4'h1;
      st_next.done = (st_reg.cnt == 4'h1);
    end
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy = (st_reg.cnt != 4'h0);
  assign last = (st_reg.cnt == 4'h1);
  assign done = st_reg.done;

endmodule

// >>> verilog/scad_decoder.sv
// scad_decoder: decoder and clock counter for the subtract/compare/adjust group
//
// Contract
// - memory into register difference: six clocks
// - difference writing memory: seven clocks
// - immediate difference, selector 101: two/seven
// - accumulator immediate difference: two clocks
// - borrow difference: two, seven, six clocks
// - immediate borrow difference, selector 011: two/seven
// - accumulator immediate borrow difference: two clocks
// - minus one: two/six; short form two
// - compare register two; memory against register five
// - compare register against memory: six clocks
// - immediate compare, selector 111: two/five
// - accumulator immediate compare: two clocks
// - sign flip, selector 011: two/six
// - unpacked add fix 37h: four clocks
// - unpacked subtract fix 3Fh: four clocks
// - packed add fix 27h: four clocks
// - packed subtract fix 2Fh: four clocks
// - register difference: two clocks
`timescale 1ns/10ps
module scad_decoder (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // prefetch queue side
  input scad_pkg::scad_byte_t fetch_in,
  output logic fetch_ready,
  // operating attributes
  input wire logic op32,
  input wire logic prot_mode,
  // sequencer side
  output logic dec_valid,
  output scad_pkg::scad_info_t dec_info,
  output logic illegal,
  output logic exec_busy,
  output logic exec_done
);

  // ----------------------------------------------------------------
  // state and wiring
  // ----------------------------------------------------------------
  scad_pkg::scad_state_t st_reg; // registered state
  scad_pkg::scad_state_t st_next; // next state
  scad_pkg::scad_info_t cls; // classification of the current bytes
  logic [7:0] opc_cur; // opcode under decode
  logic [7:0] modrm_cur; // modrm byte under decode
  logic [1:0] mod_f; // addressing form field
  logic [2:0] sel_f; // middle selector field
  logic is_reg; // addressing form names a register
  logic take; // byte accepted this cycle
  logic need_modrm; // opcode is followed by a modrm byte
  logic [2:0] imm_len; // immediate bytes after the opcode
  logic tmr_load; // start the execution count
  logic tmr_busy; // execution count running
  logic tmr_last; // final execution cycle
  logic tmr_done; // execution count finished

  // ----------------------------------------------------------------
  // byte selection
  // ----------------------------------------------------------------
  // in the modrm step the opcode comes from the held copy
  assign opc_cur = (st_reg.fsm == scad_pkg::ST_MODRM) ? st_reg.opc : fetch_in.data;
  assign modrm_cur = fetch_in.data;
  assign mod_f = modrm_cur[7:6];
  assign sel_f = modrm_cur[5:3];
  assign is_reg = (mod_f == scad_pkg::MOD_REG);

  // handshake: no new byte while an instruction executes
  assign fetch_ready = (st_reg.fsm != scad_pkg::ST_EXEC);
  assign take = fetch_in.valid && fetch_ready;

  // ----------------------------------------------------------------
  // immediate length
  // ----------------------------------------------------------------
  scad_imm_len u_imm (
    .opc(opc_cur),
    .op32(op32),
    .imm_bytes(imm_len)
  );

  // ----------------------------------------------------------------
  // modrm presence
  // ----------------------------------------------------------------
  // register/memory forms and the three selector groups carry modrm
  always_comb begin
    need_modrm = 1'b0;
    if ((opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_DIFF_RM ||
        (opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_BDIFF_RM ||
        (opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_CMP_RM ||
        (opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_IMM_GRP ||
        (opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_STEP_GRP ||
        (opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_UNARY_GRP) begin
      need_modrm = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  // common fields first, then the operation and its clock count
  always_comb begin
    cls = '0;
    cls.op = scad_pkg::OP_NONE;
    cls.clocks = scad_pkg::CLK_NONE;
    cls.wide = opc_cur[scad_pkg::BIT_W];
    cls.prot = prot_mode;
    cls.imm_bytes = imm_len;
    cls.writes_result = 1'b1;
    if ((opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_DIFF_RM ||
        (opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_BDIFF_RM ||
        (opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_CMP_RM) begin
      // register/memory with register forms
      cls.recognised = 1'b1;
      cls.dir_to_reg = opc_cur[scad_pkg::BIT_D];
      cls.reg_operand = is_reg;
      cls.reg_num = modrm_cur[5:3];
      if ((opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_CMP_RM) begin
        cls.op = scad_pkg::OP_CMP;
        cls.writes_result = 1'b0;
        if (is_reg) begin
          cls.clocks = scad_pkg::CLK_REG;
        end else if (!opc_cur[scad_pkg::BIT_D]) begin
          cls.clocks = scad_pkg::CLK_CMP_MEM_REG;
        end else begin
          cls.clocks = scad_pkg::CLK_CMP_REG_MEM;
        end
      end else begin
        // plain and borrow difference share their counts
        if ((opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_DIFF_RM) begin
          cls.op = scad_pkg::OP_DIFF;
        end else begin
          cls.op = scad_pkg::OP_BDIFF;
        end
        if (is_reg) begin
          cls.clocks = scad_pkg::CLK_REG;
        end else if (!opc_cur[scad_pkg::BIT_D]) begin
          cls.clocks = scad_pkg::CLK_MEM_TO_REG;
        end else begin
          cls.clocks = scad_pkg::CLK_REG_TO_MEM;
        end
      end
    end else if ((opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_DIFF_ACC ||
                 (opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_BDIFF_ACC ||
                 (opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_CMP_ACC) begin
      // accumulator with immediate, always two clocks
      cls.recognised = 1'b1;
      cls.dir_to_reg = 1'b1;
      cls.reg_operand = 1'b1;
      cls.clocks = scad_pkg::CLK_REG;
      if ((opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_DIFF_ACC) begin
        cls.op = scad_pkg::OP_DIFF;
      end else if ((opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_BDIFF_ACC) begin
        cls.op = scad_pkg::OP_BDIFF;
      end else begin
        cls.op = scad_pkg::OP_CMP;
        cls.writes_result = 1'b0;
      end
    end else if ((opc_cur & scad_pkg::MASK_DW) == scad_pkg::OPC_IMM_GRP) begin
      // immediate group: selector picks the operation
      cls.sext = opc_cur[scad_pkg::BIT_S] && opc_cur[scad_pkg::BIT_W];
      cls.reg_operand = is_reg;
      unique case (sel_f)
        scad_pkg::SEL_DIFF: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_DIFF;
          cls.clocks = is_reg ? scad_pkg::CLK_REG : scad_pkg::CLK_IMM_MEM;
        end
        scad_pkg::SEL_BDIFF: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_BDIFF;
          cls.clocks = is_reg ? scad_pkg::CLK_REG : scad_pkg::CLK_IMM_MEM;
        end
        scad_pkg::SEL_CMP: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_CMP;
          cls.writes_result = 1'b0;
          cls.clocks = is_reg ? scad_pkg::CLK_REG : scad_pkg::CLK_CMP_IMM_MEM;
        end
        default: begin
          // other selectors belong to other groups
          cls.recognised = 1'b0;
        end
      endcase
    end else if ((opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_STEP_GRP) begin
      // minus one on register or memory
      cls.reg_operand = is_reg;
      if (sel_f == scad_pkg::SEL_MINUS1) begin
        cls.recognised = 1'b1;
        cls.op = scad_pkg::OP_MINUS1;
        cls.clocks = is_reg ? scad_pkg::CLK_REG : scad_pkg::CLK_MINUS1_MEM;
      end
    end else if ((opc_cur & scad_pkg::MASK_W) == scad_pkg::OPC_UNARY_GRP) begin
      // sign flip on register or memory
      cls.reg_operand = is_reg;
      if (sel_f == scad_pkg::SEL_SIGNFLIP) begin
        cls.recognised = 1'b1;
        cls.op = scad_pkg::OP_SIGNFLIP;
        cls.clocks = is_reg ? scad_pkg::CLK_REG : scad_pkg::CLK_SIGNFLIP_MEM;
      end
    end else if ((opc_cur & scad_pkg::MASK_REGNUM) == scad_pkg::OPC_MINUS1_SHORT) begin
      // one-byte minus one, register in the low bits, full width
      cls.recognised = 1'b1;
      cls.op = scad_pkg::OP_MINUS1;
      cls.wide = 1'b1;
      cls.reg_operand = 1'b1;
      cls.reg_num = opc_cur[2:0];
      cls.clocks = scad_pkg::CLK_REG;
    end else begin
      // single-byte decimal adjusts on the accumulator
      cls.wide = 1'b0;
      cls.reg_operand = 1'b1;
      unique case (opc_cur)
        scad_pkg::OPC_UBCD_ADD: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_UBCD_ADD;
          cls.clocks = scad_pkg::CLK_ADJUST;
        end
        scad_pkg::OPC_UBCD_SUB: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_UBCD_SUB;
          cls.clocks = scad_pkg::CLK_ADJUST;
        end
        scad_pkg::OPC_PBCD_ADD: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_PBCD_ADD;
          cls.clocks = scad_pkg::CLK_ADJUST;
        end
        scad_pkg::OPC_PBCD_SUB: begin
          cls.recognised = 1'b1;
          cls.op = scad_pkg::OP_PBCD_SUB;
          cls.clocks = scad_pkg::CLK_ADJUST;
        end
        default: begin
          // any other byte is not ours
          cls.recognised = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // decode sequence
  // ----------------------------------------------------------------
  // opcode, optional modrm, then execution for the charged clocks
  always_comb begin
    st_next = st_reg;
    st_next.dec_valid = 1'b0;
    st_next.illegal = 1'b0;
    tmr_load = 1'b0;
    unique case (st_reg.fsm)
      scad_pkg::ST_OPCODE: begin
        if (take && need_modrm) begin
          // hold the opcode until its modrm byte arrives
          st_next.opc = fetch_in.data;
          st_next.fsm = scad_pkg::ST_MODRM;
        end else if (take) begin
          // complete with the opcode alone
          st_next.info = cls;
          st_next.dec_valid = 1'b1;
          st_next.illegal = !cls.recognised;
          tmr_load = cls.recognised;
          st_next.fsm = cls.recognised ? scad_pkg::ST_EXEC : scad_pkg::ST_OPCODE;
        end
      end
      scad_pkg::ST_MODRM: begin
        if (take) begin
          // modrm completes the decode
          st_next.info = cls;
          st_next.dec_valid = 1'b1;
          st_next.illegal = !cls.recognised;
          tmr_load = cls.recognised;
          st_next.fsm = cls.recognised ? scad_pkg::ST_EXEC : scad_pkg::ST_OPCODE;
        end
      end
      scad_pkg::ST_EXEC: begin
        // leave in the final charged clock
        if (tmr_last) begin
          st_next.fsm = scad_pkg::ST_OPCODE;
        end
      end
      default: begin
        // unused code recovers to the opcode step
        st_next.fsm = scad_pkg::ST_OPCODE;
      end
    endcase
  end

  // register the state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // execution clock count
  // ----------------------------------------------------------------
  scad_timer u_tmr (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .load(tmr_load),
    .load_cnt(cls.clocks),
    .busy(tmr_busy),
    .last(tmr_last),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dec_valid = st_reg.dec_valid;
  assign dec_info = st_reg.info;
  assign illegal = st_reg.illegal;
  assign exec_busy = tmr_busy;
  assign exec_done = tmr_done;

endmodule

// >>> dv/scad_decoder_properties.sv
// scad_decoder_properties: port-level checks of the decoder and its execution timer
`timescale 1ns/10ps
module scad_decoder_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // prefetch side
  input wire scad_pkg::scad_byte_t fetch_in,
  input wire logic fetch_ready,
  // attributes
  input wire logic op32,
  input wire logic prot_mode,
  // sequencer side
  input wire logic dec_valid,
  input wire scad_pkg::scad_info_t dec_info,
  input wire logic illegal,
  input wire logic exec_busy,
  input wire logic exec_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic dv_ok; // recognised decode this cycle
  logic adj; // decimal adjust decoded
  assign dv_ok = dec_valid && dec_info.recognised;
  assign adj = dec_info.op inside {scad_pkg::OP_UBCD_ADD, scad_pkg::OP_UBCD_SUB,
    scad_pkg::OP_PBCD_ADD, scad_pkg::OP_PBCD_SUB};
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_illegal_flag: assert property (illegal |-> dec_valid && !dec_info.recognised)
    else $error("illegal flag without unrecognised decode");
  a_ready_drops: assert property (dv_ok |-> !fetch_ready && exec_busy)
    else $error("decoder still ready while executing");
  a_two_clk_span: assert property (dv_ok && dec_info.clocks == 4'h2 |->
    exec_busy[*2] ##1 (exec_done && !exec_busy && fetch_ready))
    else $error("two clock execution span wrong");
  a_four_clk_span: assert property (dv_ok && dec_info.clocks == 4'h4 |->
    !fetch_ready[*4] ##1 fetch_ready)
    else $error("four clock execution span wrong");
  a_adjust_count: assert property (dv_ok && adj |-> dec_info.clocks == 4'h4)
    else $error("decimal adjust not four clocks");
  a_reg_count: assert property (dv_ok && dec_info.reg_operand && !adj |->
    dec_info.clocks == 4'h2)
    else $error("register operand not two clocks");
  a_mem_count: assert property (dv_ok && !dec_info.reg_operand |->
    dec_info.clocks inside {4'h5, 4'h6, 4'h7})
    else $error("memory operand count out of set");
  a_cmp_no_write: assert property (dv_ok && dec_info.op == scad_pkg::OP_CMP |->
    !dec_info.writes_result)
    else $error("compare claims a result write");
  a_done_pulse: assert property (exec_done |-> $past(exec_busy) && !exec_busy)
    else $error("done without a finished execution");
  a_info_holds: assert property (!dec_valid && $past(rstn) |-> $stable(dec_info))
    else $error("decode record changed without valid");
  // ----------------------------------------------------------------
  // coverage
  // ----------------------------------------------------------------
  c_back_to_back: cover property (exec_done ##1 dec_valid);
  c_illegal: cover property (illegal);
  c_mem_seven: cover property (dv_ok && dec_info.clocks == 4'h7);
endmodule

// >>> dv/scad_fetch_model.sv
// scad_fetch_model: prefetch queue offering instruction bytes to the decoder
`timescale 1ns/10ps
module scad_fetch_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // handshake
  input wire logic fetch_ready,
  output scad_pkg::scad_byte_t fetch_in,
  // random stalls when set
  input wire logic slow
);
  logic [7:0] q[$]; // bytes waiting to be offered
  // queue a byte from the bench
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial fetch_in = '0;
  // offer is held until taken; idle data toggles so no stale byte looks valid
  always @(posedge sys_clk) begin
    if (!rstn) begin
      fetch_in <= '0;
    end else if (!fetch_in.valid || fetch_ready) begin
      if (fetch_in.valid) void'(q.pop_front());
      if (q.size() > 0 && !(slow && $urandom_range(1) == 0)) fetch_in <= '{1'b1, q[0]};
      else fetch_in <= '{1'b0, ~fetch_in.data};
    end
  end
endmodule

// >>> dv/test_subtract_compare_adjust_decoder.sv
// test_subtract_compare_adjust_decoder: self-checking bench of the decoder
`timescale 1ns/10ps
module test_subtract_compare_adjust_decoder;
  logic sys_clk, rstn, op32, prot_mode, slow, fetch_ready, dec_valid, illegal;
  logic exec_busy, exec_done;
  scad_pkg::scad_byte_t fetch_in;
  scad_pkg::scad_info_t dec_info;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0; // timeout counter
  int eo[$]; // expected opcodes
  int em[$]; // expected modrm bytes
  int m;
  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  scad_decoder i_dut (.sys_clk(sys_clk), .rstn(rstn), .fetch_in(fetch_in),
    .fetch_ready(fetch_ready), .op32(op32), .prot_mode(prot_mode), .dec_valid(dec_valid),
    .dec_info(dec_info), .illegal(illegal), .exec_busy(exec_busy), .exec_done(exec_done));
  scad_fetch_model i_src (.sys_clk(sys_clk), .rstn(rstn), .fetch_ready(fetch_ready),
    .fetch_in(fetch_in), .slow(slow));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  function automatic bit rm_form(input int o);
    return (o >> 2) inside {10, 6, 14, 32} || (o >> 1) inside {127, 123};
  endfunction
  // clocks of an opcode/modrm pair, 0 when outside the group
  function automatic int ref_clk(input int o, input int m);
    int s, r;
    s = (m >> 3) & 7;
    r = (m >> 6) == 3;
    if ((o >> 2) inside {10, 6}) return r ? 2 : ((o & 2) ? 6 : 7);
    if ((o >> 2) == 14) return r ? 2 : ((o & 2) ? 6 : 5);
    if ((o >> 2) == 32) return (s == 5 || s == 3) ? (r ? 2 : 7) : (s == 7 ? (r ? 2 : 5) : 0);
    if ((o >> 1) == 127) return s == 1 ? (r ? 2 : 6) : 0;
    if ((o >> 1) == 123) return s == 3 ? (r ? 2 : 6) : 0;
    if ((o >> 1) inside {22, 14, 30} || (o >> 3) == 9) return 2;
    if (o inside {'h37, 'h3F, 'h27, 'h2F}) return 4;
    return 0;
  endfunction
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input int o, input int m);
    eo.push_back(o);
    em.push_back(m);
    i_src.push(8'(o));
    if (rm_form(o)) i_src.push(8'(m));
  endtask
  // wait for one decode, compare it, then time the execution
  task automatic observe();
    int o, m, c, n;
    o = eo.pop_front();
    m = em.pop_front();
    c = ref_clk(o, m);
    n = 0;
    while (dec_valid !== 1'b1 && n < 60) begin
      n++;
      @(negedge sys_clk);
    end
    check("illegal", {7'h0, illegal}, 8'(c == 0));
    check("recognised", {7'h0, dec_info.recognised}, 8'(c != 0));
    check("prot", {7'h0, dec_info.prot}, {7'h0, prot_mode});
    if (c != 0) begin
      check("clocks", {4'h0, dec_info.clocks}, 8'(c));
      check("reg", {7'h0, dec_info.reg_operand}, 8'(c == 2 || c == 4));
      check("dir", {7'h0, dec_info.dir_to_reg},
        8'(o < 64 && (rm_form(o) ? o & 2 : c == 2)));
      check("wide", {7'h0, dec_info.wide}, 8'((o >> 3) == 9 ? 1 : (c == 4 ? 0 : o & 1)));
      if ((o >> 3) == 9) check("reg_num", {5'h0, dec_info.reg_num}, 8'(o & 7));
      if ((o >> 2) == 14) check("writes", {7'h0, dec_info.writes_result}, 8'h00);
      if ((o >> 2) == 32) check("sext", {7'h0, dec_info.sext}, 8'((o & 3) == 3));
      if ((o >> 2) == 32 || (o >> 1) inside {22, 14, 30})
        check("imm", {5'h0, dec_info.imm_bytes},
          8'(((o & 2) || !(o & 1)) ? 1 : (op32 ? 4 : 2)));
    end
    n = 0;
    while (fetch_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge sys_clk);
    end
    check("ready_low", 8'(n), 8'(c));
    check("done", {7'h0, exec_done}, 8'(c != 0));
    @(negedge sys_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence: every opcode, every selector and addressing form, then random
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(38));
    rstn = 1'b0;
    op32 = 1'b0;
    prot_mode = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int o = 0; o < 256; o++) begin
      @(posedge sys_clk);
      op32 <= 1'($urandom);
      prot_mode <= 1'($urandom);
      slow <= 1'($urandom);
      @(negedge sys_clk);
      for (int k = 0; k < (rm_form(o) ? 32 : 1); k++) begin
        m = {k[1:0], k[4:2], 3'($urandom)};
        send(o, m);
      end
      while (eo.size() > 0) observe();
    end
    for (int k = 0; k < 300; k++) send($urandom_range(255), $urandom_range(255));
    while (eo.size() > 0) observe();
    summarize();
  end
endmodule
bind scad_decoder scad_decoder_chk i_chk (.sys_clk(sys_clk), .rstn(rstn), .fetch_in(fetch_in),
  .fetch_ready(fetch_ready), .op32(op32), .prot_mode(prot_mode), .dec_valid(dec_valid),
  .dec_info(dec_info), .illegal(illegal), .exec_busy(exec_busy), .exec_done(exec_done));
